// [src/wdt_pkg.sv]
// Constants, field layouts and state types of the runaway watchdog timer
package wdt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] MODE_OFFSET = 12'h000;
  localparam logic [11:0] CMD_OFFSET = 12'h004;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 7;
  localparam int PERIOD_HI = 6;
  localparam int PERIOD_LO = 4;
  localparam int IDLE_RUN_BIT = 2;
  localparam int ACTION_BIT = 1;
  localparam logic RESET_ENABLE = 1'b1;
  localparam logic [2:0] RESET_PERIOD = 3'h0;
  localparam logic RESET_IDLE_RUN = 1'b0;
  localparam logic RESET_ACTION = 1'b1;
  localparam logic [2:0] PERIOD_MAX_CODE = 3'h5;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DISABLE = 8'hB1;
  localparam logic [7:0] CMD_CLEAR = 8'h4E;

  // ----------------------------------------------------------------
  // Counter and timing
  // ----------------------------------------------------------------
  localparam int CNT_W = 26;
  localparam int PERIOD_BASE_EXP = 15;
  localparam int PERIOD_STEP_EXP = 2;
  localparam int RESET_HOLD_STATES = 32;
  localparam int HOLD_W = 6;
  localparam real CLK_PERIOD_NS = 10.0;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_RESET_HOLD = 2'b10
  } wd_phase_t;

  typedef struct packed {
    logic en;
    logic [2:0] period;
    logic idle_run;
    logic action;
    logic active;
    logic [CNT_W-1:0] cnt;
    logic [HOLD_W-1:0] hold;
    wd_phase_t phase;
    logic nmi;
    logic rst;
    logic fault_n;
    logic ph_wr;
    logic ph_rd;
    logic [1:0] ph_sel;
    logic [31:0] rdata;
  } wd_state_t;

endpackage

// [src/runaway_watchdog_timer.sv]
// Runaway watchdog timer with an AHB-Lite register slave
`timescale 1ns/10ps

// Contract
// - Period codes 0-5 give 2^15..2^25; 6,7 barred.
// - Enabled and counting straight after reset.
// - Idle halts counter unless idle run bit set.
// - Overflow gives NMI, or reset when action set.
// - Command register write-only; B1 disable, 4E clear.
// - Counter advances once every system clock.
// - Overflow issues the watchdog NMI request when action clear.
// - Optional fault pin low until clear code.
// - Counter halts while processor is in debug.
// - Watchdog NMI sets NMI source flag zero.
// - Disable is enable bit cleared, then code.
// - Clear code zeroes counter, period restarts.
// - Overflow reset held for 32 states.
module runaway_watchdog_timer #(
  parameter int HOLD_CYCLES = wdt_pkg::RESET_HOLD_STATES,
  parameter bit FAULT_PIN = 1'b0
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Processor status
  input wire logic idle_mode,
  input wire logic debug_mode,
  // Events
  output logic watchdog_nmi_request,
  output logic nmi_source_flag0_set,
  output logic wd_reset_request,
  output logic fault_out_n
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (HOLD_CYCLES < 1 || HOLD_CYCLES > (1 << wdt_pkg::HOLD_W))
  begin : g_hold_check
    $error("HOLD_CYCLES out of range");
  end

  localparam logic [wdt_pkg::HOLD_W-1:0] HOLD_LAST = wdt_pkg::HOLD_W'(HOLD_CYCLES - 1);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] reg_sel(input logic [wdt_pkg::ADDR_W-1:0] a);
    reg_sel = 2'h0;
    if (a == wdt_pkg::MODE_OFFSET)
    begin
      reg_sel = 2'h1;
    end
    else if (a == wdt_pkg::CMD_OFFSET)
    begin
      reg_sel = 2'h2;
    end
  endfunction

  function automatic logic [wdt_pkg::CNT_W-1:0] period_limit(input logic [2:0] code);
    logic [wdt_pkg::CNT_W:0] one;
    int sh;
    one = {{wdt_pkg::CNT_W{1'b0}}, 1'b1};
    sh = wdt_pkg::PERIOD_BASE_EXP + wdt_pkg::PERIOD_STEP_EXP * int'(code);
    period_limit = wdt_pkg::CNT_W'((one << sh) - 1'b1);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wdt_pkg::wd_state_t s_q;
  wdt_pkg::wd_state_t s_d;
  logic addr_ok;
  logic wr_mode;
  logic wr_cmd;
  logic [7:0] cmd;
  logic counting;
  logic ovf;
  logic clear_hit;
  logic disable_hit;

  assign addr_ok = hsel && hready && htrans[1];
  assign wr_mode = s_q.ph_wr && s_q.ph_sel[0];
  assign wr_cmd = s_q.ph_wr && s_q.ph_sel[1];
  assign cmd = hwdata[7:0];
  assign clear_hit = wr_cmd && (cmd == wdt_pkg::CMD_CLEAR);
  assign disable_hit = wr_cmd && (cmd == wdt_pkg::CMD_DISABLE) && !s_q.en;
  assign counting = s_q.active && (s_q.phase == wdt_pkg::ST_RUN) && !debug_mode
                    && !(idle_mode && !s_q.idle_run);
  assign ovf = counting && (s_q.cnt >= period_limit(s_q.period));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.nmi = 1'b0;
    // Mode register write
    if (wr_mode)
    begin
      s_d.en = hwdata[wdt_pkg::ENABLE_BIT];
      if (hwdata[wdt_pkg::PERIOD_HI:wdt_pkg::PERIOD_LO] <= wdt_pkg::PERIOD_MAX_CODE)
      begin
        s_d.period = hwdata[wdt_pkg::PERIOD_HI:wdt_pkg::PERIOD_LO];
      end
      s_d.idle_run = hwdata[wdt_pkg::IDLE_RUN_BIT];
      s_d.action = hwdata[wdt_pkg::ACTION_BIT];
      if (hwdata[wdt_pkg::ENABLE_BIT])
      begin
        s_d.active = 1'b1;
      end
    end
    // Counter
    if (counting)
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    if (ovf)
    begin
      s_d.cnt = '0;
      if (s_q.action)
      begin
        s_d.phase = wdt_pkg::ST_RESET_HOLD;
        s_d.hold = HOLD_LAST;
        s_d.rst = 1'b1;
      end
      else
      begin
        s_d.nmi = 1'b1;
        s_d.fault_n = 1'b0;
      end
    end
    if (clear_hit)
    begin
      s_d.cnt = '0;
      if (!(ovf && !s_q.action))
      begin
        s_d.fault_n = 1'b1;
      end
    end
    if (disable_hit)
    begin
      s_d.active = 1'b0;
      s_d.cnt = '0;
    end
    // Internal reset hold
    case (s_q.phase)
      wdt_pkg::ST_RUN:
      begin
      end
      wdt_pkg::ST_RESET_HOLD:
      begin
        s_d.cnt = '0;
        if (s_q.hold == '0)
        begin
          s_d.phase = wdt_pkg::ST_RUN;
          s_d.rst = 1'b0;
        end
        else
        begin
          s_d.hold = s_q.hold - 1'b1;
        end
      end
      default:
      begin
        s_d.phase = wdt_pkg::ST_RUN;
        s_d.rst = 1'b0;
      end
    endcase
    // Bus address phase
    s_d.ph_wr = addr_ok && hwrite;
    s_d.ph_rd = addr_ok && !hwrite;
    s_d.ph_sel = addr_ok ? reg_sel(haddr[wdt_pkg::ADDR_W-1:0]) : 2'h0;
    s_d.rdata = 32'h0000_0000;
    if (addr_ok && !hwrite && s_d.ph_sel[0])
    begin
      s_d.rdata[wdt_pkg::ENABLE_BIT] = s_d.en;
      s_d.rdata[wdt_pkg::PERIOD_HI:wdt_pkg::PERIOD_LO] = s_d.period;
      s_d.rdata[wdt_pkg::IDLE_RUN_BIT] = s_d.idle_run;
      s_d.rdata[wdt_pkg::ACTION_BIT] = s_d.action;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q.en <= wdt_pkg::RESET_ENABLE;
      s_q.period <= wdt_pkg::RESET_PERIOD;
      s_q.idle_run <= wdt_pkg::RESET_IDLE_RUN;
      s_q.action <= wdt_pkg::RESET_ACTION;
      s_q.active <= 1'b1;
      s_q.cnt <= '0;
      s_q.hold <= '0;
      s_q.phase <= wdt_pkg::ST_RUN;
      s_q.nmi <= 1'b0;
      s_q.rst <= 1'b0;
      s_q.fault_n <= 1'b1;
      s_q.ph_wr <= 1'b0;
      s_q.ph_rd <= 1'b0;
      s_q.ph_sel <= 2'h0;
      s_q.rdata <= 32'h0000_0000;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign watchdog_nmi_request = s_q.nmi;
  assign nmi_source_flag0_set = s_q.nmi;
  assign wd_reset_request = s_q.rst;
  assign fault_out_n = FAULT_PIN ? s_q.fault_n : 1'b1;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  period_barred_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mode && hwdata[wdt_pkg::PERIOD_HI:wdt_pkg::PERIOD_LO] > wdt_pkg::PERIOD_MAX_CODE
    |=> $stable(s_q.period))
    else $error("Barred period code stored");

  count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    counting && !ovf && !wr_cmd |=> s_q.cnt == $past(s_q.cnt) + 1'b1)
    else $error("Counter did not advance");

  idle_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    idle_mode && !s_q.idle_run && !wr_cmd && s_q.phase == wdt_pkg::ST_RUN
    |=> s_q.cnt == $past(s_q.cnt))
    else $error("Counter moved in idle");

  debug_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    debug_mode && !wr_cmd |=> s_q.cnt == $past(s_q.cnt) || s_q.cnt == '0)
    else $error("Counter moved in debug");

  nmi_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    watchdog_nmi_request |-> $past(ovf) && !$past(s_q.action) && nmi_source_flag0_set)
    else $error("NMI without overflow");

  reset_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf && s_q.action |=> wd_reset_request && !watchdog_nmi_request)
    else $error("Reset action missing");

  reset_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(wd_reset_request) |-> $past(wd_reset_request, HOLD_CYCLES)
    && !$past(wd_reset_request, HOLD_CYCLES + 1))
    else $error("Reset pulse length wrong");

  cmd_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.ph_rd |-> hrdata[31:8] == 24'h0 && hrdata[3] == 1'b0 && hrdata[0] == 1'b0
    && (!s_q.ph_sel[1] || hrdata == 32'h0))
    else $error("Reserved read bits set");

  clear_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clear_hit |=> s_q.cnt == '0)
    else $error("Clear code missed");

  disable_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_cmd && cmd == wdt_pkg::CMD_DISABLE |=> s_q.active == $past(s_q.active && s_q.en)
    || (s_q.active && $past(wr_mode)))
    else $error("Disable gating wrong");

  reserved_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_cmd && cmd != wdt_pkg::CMD_DISABLE && cmd != wdt_pkg::CMD_CLEAR
    |=> $stable(s_q.active) && $stable(s_q.en) && $stable(s_q.period))
    else $error("Reserved command acted");

  fault_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
    watchdog_nmi_request && FAULT_PIN |-> !fault_out_n)
    else $error("Fault pin not low");

  fault_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    FAULT_PIN && clear_hit && !(ovf && !s_q.action) |=> fault_out_n)
    else $error("Fault pin not released");

  nmi_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    watchdog_nmi_request |=> !watchdog_nmi_request)
    else $error("NMI longer than one cycle");

endmodule

// [tb/runaway_watchdog_timer_bench.sv]
// Self-checking bench for the runaway watchdog timer
`timescale 1ns/10ps
module runaway_watchdog_timer_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int HOLD = 4;
  localparam int LO = 32760;
  localparam int HI = 32780;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic idle_mode = 1'b0;
  logic debug_mode = 1'b0;
  wire logic hready;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic nmi;
  wire logic flag0;
  wire logic rst_req;
  wire logic fault_n;
  int error_cnt = 0;
  int tests_run = 0;

  always #5 hclk = ~hclk;

  runaway_watchdog_timer #(.HOLD_CYCLES(HOLD), .FAULT_PIN(1'b1)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .idle_mode(idle_mode),
    .debug_mode(debug_mode), .watchdog_nmi_request(nmi), .nmi_source_flag0_set(flag0),
    .wd_reset_request(rst_req), .fault_out_n(fault_n)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    check(what, rd, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic wait_evt(input bit rsel, output int n);
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while ((rsel ? rst_req : nmi) !== 1'b1 && n < 40000);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_map;
    rd_chk("mode_reset", 32'h0, 32'h00000082);
    rd_chk("cmd_read", 32'h4, 32'h0);
    check("bus_okay", {hready, hresp}, 32'h2);
    wr_reg(32'h0, 32'h000000D2);
    rd_chk("mode_period", 32'h0, 32'h000000D2);
    wr_reg(32'h0, 32'h00000082);
    wr_reg(32'h10, 32'hFFFFFFFF);
    rd_chk("unmapped", 32'h10, 32'h0);
    rd_chk("mode_kept", 32'h0, 32'h00000082);
    check("fault_idle", fault_n, 1'b1);
    $display("test reset_map done");
  endtask

  task automatic test_disable_reset;
    int n;
    int h;
    wr_reg(32'h0, 32'h00000002);
    wait_cyc(20);
    wr_reg(32'h4, 32'h000000B1);
    rd_chk("mode_off", 32'h0, 32'h00000002);
    idle_mode <= 1'b1;
    wr_reg(32'h0, 32'hFFFFFFF7);
    wait_cyc(100);
    wr_reg(32'h4, 32'h000000B1);
    wr_reg(32'h4, 32'h00000055);
    rd_chk("mode_on", 32'h0, 32'h00000086);
    wait_evt(1'b1, n);
    n += 106;
    check("rst_time", n >= LO && n <= HI, 1'b1);
    check("no_nmi", nmi, 1'b0);
    h = 0;
    while (rst_req === 1'b1 && h < 100)
    begin
      h++;
      @(posedge hclk);
    end
    check("rst_hold", h, HOLD);
    idle_mode <= 1'b0;
    $display("test disable_reset done");
  endtask

  task automatic test_nmi;
    int n;
    wr_reg(32'h0, 32'h00000080);
    rd_chk("mode_nmi", 32'h0, 32'h00000080);
    wr_reg(32'h4, 32'h0000004E);
    wait_cyc(1000);
    debug_mode <= 1'b1;
    wait_cyc(1000);
    debug_mode <= 1'b0;
    idle_mode <= 1'b1;
    wait_cyc(1000);
    idle_mode <= 1'b0;
    wait_evt(1'b0, n);
    n += 3000;
    check("nmi_time", n >= LO + 2000 && n <= HI + 2000, 1'b1);
    check("flag0", flag0, 1'b1);
    check("no_rst", rst_req, 1'b0);
    @(posedge hclk);
    check("nmi_pulse", nmi, 1'b0);
    check("fault_low", fault_n, 1'b0);
    wr_reg(32'h4, 32'h0000004E);
    wait_cyc(2);
    check("fault_high", fault_n, 1'b1);
    $display("test nmi done");
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset_map();
    test_disable_reset();
    test_nmi();
    report_and_stop();
  end

  initial
  begin
    #900000;
    error_cnt++;
    report_and_stop();
  end
endmodule
